// ### ccsu_pkg.sv
// Package of constants, types and command codes for the common command status unit
package ccsu_pkg;

    // Command codes presented on the command port
    typedef enum logic [3:0] {
        CMD_NONE   = 4'h0,
        CMD_OPT    = 4'h1,
        CMD_RCL    = 4'h2,
        CMD_RST    = 4'h3,
        CMD_SAV    = 4'h4,
        CMD_SRE    = 4'h5,
        CMD_SREQ   = 4'h6,
        CMD_STBQ   = 4'h7,
        CMD_TRG    = 4'h8,
        CMD_TST    = 4'h9,
        CMD_WAI    = 4'hA,
        CMD_INIT   = 4'hB,
        CMD_INITC  = 4'hC,
        CMD_OUTP   = 4'hD,
        CMD_SPOLL  = 4'hE,
        CMD_SETTRG = 4'hF
    } cmd_t;

    typedef enum logic [1:0] {
        FMODE_VOLT = 2'h0,
        FMODE_CURR = 2'h1
    } fmode_t;

    localparam int LVL_W = 16;

    // Triggered settings held in memory and in the trigger control section
    typedef struct packed {
        logic [LVL_W-1:0] volt;
        logic [LVL_W-1:0] curr;
        fmode_t           mode;
    } trig_set_t;

    // Command request from the message parser
    typedef struct packed {
        cmd_t             code;
        logic [7:0]       arg;
        trig_set_t        data;
    } cmd_req_t;

    // Status inputs that feed the status byte
    typedef struct packed {
        logic oper;
        logic esb;
        logic mav;
        logic ques;
        logic errq;
    } stb_src_t;

    localparam logic [6:0] MEM_LOCS    = 7'h63;
    localparam logic [6:0] MEM_FIRST   = 7'h01;
    localparam int         MEM_ADDR_W  = 7;

    // Status byte bit positions
    localparam int STB_OPER = 7;
    localparam int STB_MSS  = 6;
    localparam int STB_ESB  = 5;
    localparam int STB_MAV  = 4;
    localparam int STB_QUES = 3;
    localparam int STB_ERRQ = 2;

    localparam logic [7:0]       SRE_RESET  = 8'h00;
    localparam logic [LVL_W-1:0] LVL_ZERO   = 16'h0000;
    localparam logic [7:0]       TST_PASS   = 8'h00;

    // Option string length and characters
    localparam int         OPT_LEN     = 15;
    localparam logic [3:0] OPT_LAST    = 4'hE;
    localparam logic [7:0] OPT_STEPS_H = 8'h39;
    localparam logic [7:0] OPT_STEPS_L = 8'h39;

endpackage : ccsu_pkg

// ### ccsu_trig_mem.sv
// Flip-flop store for saved trigger settings, indexed 1 to 99
`timescale 1ns/1ps
`default_nettype none
module ccsu_trig_mem (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          wr_en,
    input  wire logic [ccsu_pkg::MEM_ADDR_W-1:0] addr,
    input  wire ccsu_pkg::trig_set_t           wr_data,
    output ccsu_pkg::trig_set_t                rd_data
);
    import ccsu_pkg::*;

    trig_set_t mem [1:MEM_LOCS];

    // Reads are registered so the recalled word comes from flip-flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[addr];
        end
    end

    // Contents are not cleared by reset, as with non-volatile storage
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end
endmodule // ccsu_trig_mem
`default_nettype wire

// ### ccsu_top.sv
// Common command and status byte unit for a power supply interface card
//
// Functional notes
// (R1) Option query returns capability ASCII string
// (R2) Recall takes index 1 to 99
// (R3) First recall loads trigger section; second applies
// (R4) Recall affects trigger volt, curr, mode
// (R5) Reset: output off, levels zero, voltage mode
// (R6) Reset clears overvoltage and overcurrent latches
// (R7) Output stays off until output-on command
// (R8) Reset returns voltage mode and auto range
// (R9) Save writes present state to location
// (R10) Save stores trigger volt, curr, mode
// (R11) Enable mask bit 6 never programmable
// (R12) Enabled status bits ORed into bit 6
// (R13) Serial poll clears RQS; reading keeps MSS
// (R14) Status query returns MSS, clears nothing
// (R15) Serial poll returns RQS then resets it
// (R16) Enable query returns current mask
// (R17) Status byte bit assignment fixed
// (R18) Armed trigger applies levels, clears waiting
// (R19) Continuous initiation re-arms after trigger
// (R20) Trigger only acted on when listener
// (R21) Self test runs all, returns fail bits
// (R22) Wait defers commands until all complete
// (R23) Unarmed trigger leaves output unchanged
// (R24) Bad save/recall index rejected
`timescale 1ns/1ps
`default_nettype none
module ccsu_top (
    input  wire logic                       CLK,
    input  wire logic                       RESET_N,
    input  wire logic                       CMD_VALID,
    output logic                            CMD_READY,
    input  wire ccsu_pkg::cmd_req_t         CMD,
    input  wire logic                       LISTENER,
    input  wire logic                       OP_PENDING,
    input  wire ccsu_pkg::stb_src_t         STB_SRC,
    input  wire logic [7:0]                 SELFTEST_FAIL,
    input  wire logic                       OVP_TRIP,
    input  wire logic                       OCP_TRIP,
    output logic                            RSP_VALID,
    output logic [7:0]                      RSP_DATA,
    output logic                            RSP_LAST,
    output logic                            OUT_ON,
    output logic [ccsu_pkg::LVL_W-1:0]      OUT_VOLT,
    output logic [ccsu_pkg::LVL_W-1:0]      OUT_CURR,
    output ccsu_pkg::fmode_t                OUT_MODE,
    output logic                            RANGE_AUTO,
    output logic                            WAITING_TRIG,
    output logic                            PROT_LATCH,
    output logic                            CMD_REJECT,
    output logic                            SRQ
);
    import ccsu_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers

    logic       rst_meta;
    logic       rst_n;
    logic [1:0] listen_sync;
    logic [1:0] pend_sync;
    logic [1:0] ovp_sync;
    logic [1:0] ocp_sync;

    // Release reset through two flip-flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Pin levels pass two flip-flops; only the second stage is read
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            listen_sync <= 2'h0;
            pend_sync <= 2'h0;
            ovp_sync  <= 2'h0;
            ocp_sync  <= 2'h0;
        end else begin
            listen_sync <= {listen_sync[0], LISTENER};
            pend_sync <= {pend_sync[0], OP_PENDING};
            ovp_sync  <= {ovp_sync[0], OVP_TRIP};
            ocp_sync  <= {ocp_sync[0], OCP_TRIP};
        end
    end

    wire listener   = listen_sync[1];
    wire op_pending = pend_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // Command decode

    typedef enum logic [1:0] {ST_IDLE, ST_RECALL, ST_OPT} state_t;

    state_t     state;
    state_t     next_state;
    logic       wai_hold;
    logic [3:0] opt_idx;
    logic       rcl_loaded;
    trig_set_t  trig_sect;
    logic       init_cont;
    logic [7:0] service_request_mask;
    logic       rqs;
    logic       mss_prev;

    // Index range check, used by both save and recall
    function automatic logic idx_ok(input logic [7:0] idx);
        idx_ok = (idx >= {1'b0, MEM_FIRST}) && (idx <= {1'b0, MEM_LOCS});
    endfunction

    // Wait blocks further commands while earlier work is still pending
    assign CMD_READY = (state == ST_IDLE) && !(wai_hold && op_pending); // R22
    wire   take      = CMD_VALID && CMD_READY;
    wire   cmd_rcl   = take && (CMD.code == CMD_RCL);
    wire   cmd_sav   = take && (CMD.code == CMD_SAV);
    wire   cmd_rst   = take && (CMD.code == CMD_RST);
    wire   cmd_trg   = take && (CMD.code == CMD_TRG) && listener; // R20
    wire   arg_ok    = idx_ok(CMD.arg); // R2
    wire   sav_go    = cmd_sav && arg_ok; // R24
    wire   rcl_go    = cmd_rcl && arg_ok; // R24
    wire   rcl_first = rcl_go && !rcl_loaded;
    wire   rcl_apply = rcl_go && rcl_loaded;
    wire   spoll     = take && (CMD.code == CMD_SPOLL);

    ////////////////////////////////////////////////////////////////////////////
    // Trigger setting store

    trig_set_t mem_rd;

    // Save writes the present triggered settings
    ccsu_trig_mem u_mem (
        .clk     (CLK),
        .rst_n   (rst_n),
        .wr_en   (sav_go), // R9
        .addr    (CMD.arg[MEM_ADDR_W-1:0]),
        .wr_data (trig_sect), // R10
        .rd_data (mem_rd)
    );

    // Sequencer: recall waits one cycle for the registered read
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (rcl_first) begin
                    next_state = ST_RECALL;
                end else if (take && CMD.code == CMD_OPT) begin
                    next_state = ST_OPT;
                end
            end
            ST_RECALL: begin
                next_state = ST_IDLE;
            end
            ST_OPT: begin
                if (opt_idx == OPT_LAST) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger control section and output channel

    // Recall loads the section first; a second recall applies it
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            trig_sect  <= '0;
            rcl_loaded <= 1'b0;
        end else if (state == ST_RECALL) begin
            trig_sect  <= mem_rd; // R3 R4
            rcl_loaded <= 1'b1;
        end else if (rcl_apply) begin
            rcl_loaded <= 1'b0; // R3
        end else if (take && CMD.code == CMD_SETTRG) begin
            trig_sect  <= CMD.data;
        end
    end

    // Output levels change only by reset, trigger or applied recall
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            OUT_ON     <= 1'b0;
            OUT_VOLT   <= LVL_ZERO;
            OUT_CURR   <= LVL_ZERO;
            OUT_MODE   <= FMODE_VOLT;
            RANGE_AUTO <= 1'b1;
        end else if (cmd_rst) begin
            OUT_ON     <= 1'b0; // R5 R7
            OUT_VOLT   <= LVL_ZERO; // R5
            OUT_CURR   <= LVL_ZERO; // R5
            OUT_MODE   <= FMODE_VOLT; // R5 R8
            RANGE_AUTO <= 1'b1; // R8
        end else if ((cmd_trg && WAITING_TRIG) || rcl_apply) begin
            OUT_VOLT   <= trig_sect.volt; // R18 R23
            OUT_CURR   <= trig_sect.curr; // R18
            OUT_MODE   <= trig_sect.mode;
        end else if (take && CMD.code == CMD_OUTP) begin
            OUT_ON     <= CMD.arg[0]; // R7
        end
    end

    // Arming: a trigger clears waiting, continuous mode re-arms at once
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            WAITING_TRIG <= 1'b0;
            init_cont    <= 1'b0;
        end else if (cmd_rst) begin
            WAITING_TRIG <= 1'b0;
            init_cont    <= 1'b0;
        end else if (cmd_trg && WAITING_TRIG) begin
            WAITING_TRIG <= init_cont; // R18 R19
        end else if (take && CMD.code == CMD_INIT) begin
            WAITING_TRIG <= 1'b1;
        end else if (take && CMD.code == CMD_INITC) begin
            init_cont    <= CMD.arg[0];
            WAITING_TRIG <= WAITING_TRIG | CMD.arg[0];
        end
    end

    // Protection latch: a new trip wins over the reset command
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PROT_LATCH <= 1'b0;
        end else if (ovp_sync[1] || ocp_sync[1]) begin
            PROT_LATCH <= 1'b1;
        end else if (cmd_rst) begin
            PROT_LATCH <= 1'b0; // R6
        end
    end

    // Wait holds the port until pending operations finish
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wai_hold <= 1'b0;
        end else if (take && CMD.code == CMD_WAI) begin
            wai_hold <= 1'b1; // R22
        end else if (!op_pending) begin
            wai_hold <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status byte and service request

    wire [7:0] stb_base = {STB_SRC.oper, 1'b0, STB_SRC.esb, STB_SRC.mav,
                           STB_SRC.ques, STB_SRC.errq, 2'b00}; // R17
    wire       mss      = |(stb_base & service_request_mask); // R12
    wire [7:0] stb_mss  = stb_base | ({7'h00, mss} << STB_MSS); // R14
    wire [7:0] stb_rqs  = stb_base | ({7'h00, rqs} << STB_MSS); // R15

    // Mask register; bit 6 is forced off whatever is written
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            service_request_mask <= SRE_RESET;
        end else if (take && CMD.code == CMD_SRE) begin
            service_request_mask <= CMD.arg & ~(8'h01 << STB_MSS); // R11
        end
    end

    // RQS sets on a rising summary; a new request wins over the poll clear
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rqs      <= 1'b0;
            mss_prev <= 1'b0;
        end else begin
            mss_prev <= mss;
            if (mss && !mss_prev) begin
                rqs <= 1'b1;
            end else if (spoll) begin
                rqs <= 1'b0; // R13 R15
            end
        end
    end

    assign SRQ = rqs;

    ////////////////////////////////////////////////////////////////////////////
    // Responses

    // Option string: capability tokens, one character per index
    function automatic logic [7:0] opt_char(input logic [3:0] i);
        logic [7:0] c;
        c = 8'h20;
        unique case (i)
            4'h0: c = 8'h43;
            4'h1: c = 8'h41;
            4'h2: c = 8'h4C;
            4'h3: c = 8'h2C;
            4'h4: c = 8'h52;
            4'h5: c = 8'h4C;
            4'h6: c = 8'h31;
            4'h7: c = 8'h2C;
            4'h8: c = 8'h4D;
            4'h9: c = 8'h45;
            4'hA: c = 8'h4D;
            4'hB: c = OPT_STEPS_H;
            4'hC: c = OPT_STEPS_L;
            4'hD: c = 8'h2C;
            4'hE: c = 8'h4C;
            default: c = 8'h20;
        endcase
        opt_char = c;
    endfunction

    // One byte per cycle; the option string streams after the request
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RSP_VALID  <= 1'b0;
            RSP_DATA   <= 8'h00;
            RSP_LAST   <= 1'b0;
            opt_idx    <= 4'h0;
            CMD_REJECT <= 1'b0;
        end else begin
            RSP_VALID  <= 1'b0;
            RSP_LAST   <= 1'b0;
            CMD_REJECT <= (cmd_sav || cmd_rcl) && !arg_ok; // R24
            if (state == ST_OPT) begin
                RSP_VALID <= 1'b1;
                RSP_DATA  <= opt_char(opt_idx); // R1
                RSP_LAST  <= (opt_idx == OPT_LAST);
                opt_idx   <= (opt_idx == OPT_LAST) ? 4'h0 : opt_idx + 4'h1;
            end else if (take) begin
                RSP_LAST <= 1'b1;
                unique case (CMD.code)
                    CMD_SREQ: begin
                        RSP_VALID <= 1'b1;
                        RSP_DATA  <= service_request_mask; // R16
                    end
                    CMD_STBQ: begin
                        RSP_VALID <= 1'b1;
                        RSP_DATA  <= stb_mss; // R14
                    end
                    CMD_SPOLL: begin
                        RSP_VALID <= 1'b1;
                        RSP_DATA  <= stb_rqs; // R15
                    end
                    CMD_TST: begin
                        RSP_VALID <= 1'b1;
                        RSP_DATA  <= TST_PASS | SELFTEST_FAIL; // R21
                    end
                    default: begin
                        RSP_LAST <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // ccsu_top
`default_nettype wire

// ### ccsu_checker.sv
// Assertion checker on the ports of the common command status unit
`timescale 1ns/1ps
`default_nettype none
module ccsu_checker (
    input wire logic                  CLK,
    input wire logic                  RESET_N,
    input wire logic                  CMD_VALID,
    input wire logic                  CMD_READY,
    input wire ccsu_pkg::cmd_req_t    CMD,
    input wire ccsu_pkg::stb_src_t    STB_SRC,
    input wire logic                  RSP_VALID,
    input wire logic [7:0]            RSP_DATA,
    input wire logic                  RSP_LAST,
    input wire logic                  OUT_ON,
    input wire logic [15:0]           OUT_VOLT,
    input wire logic [15:0]           OUT_CURR,
    input wire ccsu_pkg::fmode_t      OUT_MODE,
    input wire logic                  RANGE_AUTO,
    input wire logic                  WAITING_TRIG,
    input wire logic                  CMD_REJECT,
    input wire logic                  SRQ
);
    import ccsu_pkg::*;

    // Request taken, and an index outside the stored locations
    wire logic take    = CMD_VALID && CMD_READY;
    wire logic bad_idx = CMD.arg == 8'h00 || CMD.arg > 8'h63;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    ////////////////////////////////////////////////////////////////////////////
    a_query_single: assert property (take && CMD.code inside {CMD_STBQ, CMD_SREQ, CMD_SPOLL,
        CMD_TST} |=> RSP_VALID && RSP_LAST) else $error("query answer not one byte");
    a_opt_stream: assert property (take && CMD.code == CMD_OPT |=> !RSP_VALID ##1
        RSP_VALID [*8] ##7 RSP_LAST && RSP_DATA == 8'h4C) else $error("option stream bad");
    a_mask_bit6: assert property (take && CMD.code == CMD_SREQ |=> !RSP_DATA[6])
        else $error("mask query shows bit 6");
    a_stb_layout: assert property (take && CMD.code == CMD_STBQ |=> RSP_DATA[1:0] == 2'b00
        && RSP_DATA[5] == $past(STB_SRC.esb) && RSP_DATA[7] == $past(STB_SRC.oper))
        else $error("status byte layout wrong");
    a_poll_rqs: assert property (take && CMD.code == CMD_SPOLL |=> RSP_DATA[6] == $past(SRQ))
        else $error("poll bit 6 is not the request bit");
    a_bad_index: assert property (take && CMD.code inside {CMD_SAV, CMD_RCL} && bad_idx
        |=> CMD_REJECT && $stable(OUT_VOLT)) else $error("bad index not refused");
    a_trg_unarmed: assert property (take && CMD.code == CMD_TRG && !WAITING_TRIG |=>
        ($stable(OUT_VOLT) && $stable(OUT_CURR)) [*2]) else $error("unarmed trigger moved");
    a_rst_levels: assert property (take && CMD.code == CMD_RST |-> ##[1:2] !OUT_ON &&
        OUT_VOLT == LVL_ZERO && OUT_CURR == LVL_ZERO) else $error("reset left output up");
    a_rst_mode: assert property (take && CMD.code == CMD_RST |-> ##[1:2] RANGE_AUTO &&
        OUT_MODE == FMODE_VOLT) else $error("reset left mode or range");
endmodule // ccsu_checker

bind ccsu_top ccsu_checker ccsu_checker_i (.CLK, .RESET_N, .CMD_VALID, .CMD_READY, .CMD,
    .STB_SRC, .RSP_VALID, .RSP_DATA, .RSP_LAST, .OUT_ON, .OUT_VOLT, .OUT_CURR, .OUT_MODE,
    .RANGE_AUTO, .WAITING_TRIG, .CMD_REJECT, .SRQ);
`default_nettype wire

// ### ccsu_ctl.sv
// Remote bus controller model that hands commands to the unit
`timescale 1ns/1ps
`default_nettype none
module ccsu_ctl (
    input  wire logic          CLK,
    input  wire logic          CMD_READY,
    output var logic           CMD_VALID,
    output ccsu_pkg::cmd_req_t CMD
);
    import ccsu_pkg::*;

    initial begin
        CMD_VALID = 1'b0;
        CMD = '0;
    end

    // Hold the request up to the rising edge that samples ready high, then
    // scramble the idle lines so a design sampling them outside a request
    // sees garbage; a hang is left to the bench watchdog
    task automatic issue(input cmd_t code, input logic [7:0] arg, input trig_set_t d);
        @(posedge CLK);
        CMD_VALID <= 1'b1;
        CMD <= '{code, arg, d};
        do begin
            @(posedge CLK);
        end while (CMD_READY !== 1'b1);
        CMD_VALID <= 1'b0;
        CMD <= cmd_req_t'(~CMD);
    endtask
endmodule // ccsu_ctl
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the common command status unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ccsu_pkg::*;
    logic              CLK = 1'b0;
    logic              RESET_N = 1'b0;
    logic              LISTENER = 1'b0;
    logic              OP_PENDING = 1'b0;
    logic              OVP_TRIP = 1'b0;
    logic              OCP_TRIP = 1'b0;
    stb_src_t          STB_SRC = '0;
    logic [7:0]        SELFTEST_FAIL = 8'h00;
    logic              CMD_VALID, CMD_READY, RSP_VALID, RSP_LAST, OUT_ON, RANGE_AUTO;
    logic              WAITING_TRIG, PROT_LATCH, CMD_REJECT, SRQ;
    cmd_req_t          CMD;
    logic [7:0]        RSP_DATA, r;
    logic [15:0]       OUT_VOLT, OUT_CURR;
    fmode_t            OUT_MODE;
    trig_set_t         d1, d2;
    logic [8:0]        exp_q[$];
    int                mismatches = 0;
    int                n_compared = 0;
    localparam trig_set_t    ZERO_SET = '{LVL_ZERO, LVL_ZERO, FMODE_VOLT};
    localparam logic [119:0] OPT_EXP  = 120'h43414C2C524C312C4D454D39392C4C;
    wire logic [35:0]  outs = {OUT_ON, RANGE_AUTO, OUT_VOLT, OUT_CURR, OUT_MODE};

    always #50 CLK = ~CLK;

    ccsu_ctl ctl_i (.CLK, .CMD_READY, .CMD_VALID, .CMD);
    ccsu_top ccsu_top_i (.CLK, .RESET_N, .CMD_VALID, .CMD_READY, .CMD, .LISTENER, .OP_PENDING,
        .STB_SRC, .SELFTEST_FAIL, .OVP_TRIP, .OCP_TRIP, .RSP_VALID, .RSP_DATA, .RSP_LAST,
        .OUT_ON, .OUT_VOLT, .OUT_CURR, .OUT_MODE, .RANGE_AUTO, .WAITING_TRIG, .PROT_LATCH,
        .CMD_REJECT, .SRQ);

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task automatic cmd(input cmd_t c, input logic [7:0] a = 8'h00, input trig_set_t d = '0);
        ctl_i.issue(c, a, d);
    endtask
    // Note the single byte a query should return, then send it
    task automatic query(input cmd_t c, input logic [7:0] exp);
        exp_q.push_back({1'b1, exp});
        ctl_i.issue(c, 8'h00, '0);
    endtask
    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Each response byte is matched against the oldest note in the queue
    always @(posedge CLK) begin
        if (RSP_VALID === 1'b1) begin
            if (exp_q.size() == 0) check("spare byte", 40'h1, 40'h0);
            else check("response", {RSP_LAST, RSP_DATA}, exp_q.pop_front());
        end
    end

    // Watchdog sized well above the few hundred cycles the sequence needs
    initial begin
        cyc(6000);
        mismatches++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h5631));
        cyc(5);
        RESET_N <= 1'b1;
        cyc(4);
        check("power on", outs, {2'b01, ZERO_SET});
        for (int i = 0; i < 15; i++) exp_q.push_back({i == 14, OPT_EXP[119-8*i -: 8]});
        cmd(CMD_OPT);
        cyc(18);
        // Mask writes with bit 6 set must read back without it; sources idle
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 8'hFF : (i == 1) ? 8'h40 : 8'($urandom);
            cmd(CMD_SRE, r);
            query(CMD_SREQ, r & 8'hBF);
        end
        cmd(CMD_SRE, 8'h00);
        STB_SRC <= 5'($urandom);
        cyc(1);
        repeat (2) query(CMD_STBQ, {STB_SRC[4], 1'b0, STB_SRC[3:0], 2'b00});
        STB_SRC <= 5'h08;
        cmd(CMD_SRE, 8'h20);
        cyc(2);
        check("request set", SRQ, 1'b1);
        query(CMD_SPOLL, 8'h60);
        query(CMD_SPOLL, 8'h20);
        query(CMD_STBQ, 8'h60);
        cyc(2);
        check("request line", SRQ, 1'b0);
        for (int i = 0; i < 3; i++) begin
            SELFTEST_FAIL <= (i == 0) ? TST_PASS : 8'($urandom);
            cyc(1);
            query(CMD_TST, SELFTEST_FAIL);
        end
        // Save, then two recalls: the first only loads the trigger section
        d1 = '{16'($urandom), 16'($urandom), FMODE_CURR};
        d2 = '{16'($urandom), 16'($urandom), FMODE_VOLT};
        r = 8'(1 + $urandom % 99);
        cmd(CMD_SETTRG, 8'h00, d1);
        cmd(CMD_SAV, r);
        cmd(CMD_SETTRG, 8'h00, d2);
        cmd(CMD_RCL, r);
        cyc(3);
        check("first recall", outs, {2'b01, ZERO_SET});
        cmd(CMD_RCL, r);
        cyc(3);
        check("second recall", outs, {2'b01, d1});
        for (int i = 0; i < 4; i++) begin
            cmd((i % 2) ? CMD_RCL : CMD_SAV, (i < 2) ? 8'h00 : 8'h64);
            @(negedge CLK);
            check("refused index", CMD_REJECT, 1'b1);
        end
        // Trigger: armed but not listening, listening, unarmed, continuous
        cmd(CMD_SETTRG, 8'h00, d2);
        cmd(CMD_INIT);
        cmd(CMD_TRG);
        cyc(3);
        check("not listener", {WAITING_TRIG, outs}, {3'b101, d1});
        LISTENER <= 1'b1;
        cyc(3);
        cmd(CMD_TRG);
        cyc(3);
        check("trigger", {WAITING_TRIG, outs}, {3'b001, d2});
        cmd(CMD_SETTRG, 8'h00, d1);
        cmd(CMD_TRG);
        cyc(3);
        check("unarmed", {WAITING_TRIG, outs}, {3'b001, d2});
        cmd(CMD_INITC, 8'h01);
        cmd(CMD_INIT);
        cmd(CMD_TRG);
        cyc(3);
        check("rearm", {WAITING_TRIG, outs}, {3'b101, d1});
        // Each protection trip latches; reset clears it and the output
        for (int i = 0; i < 2; i++) begin
            cmd(CMD_OUTP, 8'h01);
            cyc(3);
            check("output on", OUT_ON, 1'b1);
            {OVP_TRIP, OCP_TRIP} <= (i == 0) ? 2'b10 : 2'b01;
            cyc(4);
            {OVP_TRIP, OCP_TRIP} <= 2'b00;
            cyc(4);
            check("trip latched", PROT_LATCH, 1'b1);
            cmd(CMD_RST);
            cyc(3);
            check("reset", {PROT_LATCH, WAITING_TRIG, outs}, {4'b0001, ZERO_SET});
        end
        cmd(CMD_RCL, r);
        cmd(CMD_RCL, r);
        cyc(3);
        check("stays off", OUT_ON, 1'b0);
        // Wait holds later commands while operations are outstanding
        OP_PENDING <= 1'b1;
        cmd(CMD_WAI);
        cyc(4);
        check("wait holds", CMD_READY, 1'b0);
        fork
            begin
                cyc(20);
                OP_PENDING <= 1'b0;
            end
        join_none
        query(CMD_STBQ, 8'h60);
        cyc(5);
        check("queue drained", 40'(exp_q.size()), 40'h0);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
